//--- core/serial_ctrl_pkg.sv
// constants, carriers and helpers for the quad serial line controller
`default_nettype none
package serial_ctrl_pkg;
  localparam int NUM_LINES = 4;
  localparam int SILO_DEPTH = 64;
  localparam int STAGE_DEPTH = 4;
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int OVERSAMPLE = 16;
  localparam int SILO_ALARM = 16;
  localparam int COMM_LINE = 2;
  localparam int PRINTER_LINE = 3;
  // register select codes
  localparam logic [1:0] REG_CSR = 2'h0;
  localparam logic [1:0] REG_RBUF_LPR = 2'h1;
  localparam logic [1:0] REG_TCR = 2'h2;
  localparam logic [1:0] REG_MSR_TDR = 2'h3;
  // csr fields
  localparam int CSR_TRDY = 15;
  localparam int CSR_TIE = 14;
  localparam int CSR_SA = 13;
  localparam int CSR_SAE = 12;
  localparam int CSR_TLINE = 8;
  localparam int CSR_RDONE = 7;
  localparam int CSR_RIE = 6;
  localparam int CSR_MSE = 5;
  localparam int CSR_CLR = 4;
  // line parameter fields
  localparam int LPR_LINE = 0;
  localparam int LPR_RATE = 8;
  localparam int LPR_RXEN = 12;
  // transmit control fields
  localparam int TCR_TXEN = 0;
  localparam int TCR_MODEM = 8;
  // receive buffer high byte fields
  localparam int RB_VALID = 7;
  localparam int RB_FERR = 5;
  localparam logic [3:0] RATE_RESET = 4'hE;
  localparam logic [15:0] READ_NONE = 16'h0000;

  typedef struct packed {
    logic [1:0] line;
    logic ferr;
    logic [7:0] ch;
  } rx_char_s;

  typedef struct packed {
    logic wr_hi;
    logic wr_lo;
    logic rd;
    logic [1:0] sel;
    logic [15:0] data;
  } host_in_s;

  typedef struct packed {
    logic llbk;
    logic dtr;
    logic dsrs;
    logic rts;
  } modem_s;

  typedef enum logic [1:0] {LD_IDLE, LD_LOW, LD_HIGH} load_e;

  // clock cycles per oversample tick for each rate code
  function automatic logic [15:0] div_for(input logic [3:0] idx);
    int rate;
    rate = 9600;
    case (idx)
      4'h0: rate = 50;
      4'h1: rate = 75;
      4'h2: rate = 110;
      4'h3: rate = 134;
      4'h4: rate = 150;
      4'h5: rate = 300;
      4'h6: rate = 600;
      4'h7: rate = 1200;
      4'h8: rate = 1800;
      4'h9: rate = 2000;
      4'hA: rate = 2400;
      4'hB: rate = 3600;
      4'hC: rate = 4800;
      4'hD: rate = 7200;
      4'hE: rate = 9600;
      default: rate = 19200;
    endcase
    return 16'(CLK_HZ / (OVERSAMPLE * rate));
  endfunction : div_for

  // index of the lowest set bit
  function automatic logic [1:0] first_set(input logic [3:0] v);
    first_set = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
  endfunction : first_set
endpackage : serial_ctrl_pkg
`default_nettype wire

//--- core/serial_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
`default_nettype none
module serial_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
    $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign count = wp_q - rp_q;
  assign in_ready = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rp_q[AW-1:0]];
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (clear) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (push) mem[wp_q[AW-1:0]] <= in_data;
  end
endmodule : serial_fifo
`default_nettype wire

//--- core/quad_serial_line_silo_controller.sv
// quad serial line controller with shared receive silo
`timescale 1ns/1ps
`default_nettype none
module quad_serial_line_silo_controller
  import serial_ctrl_pkg::*;
#(
  parameter int SILO_WORDS = SILO_DEPTH,
  parameter int STAGE_WORDS = STAGE_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic system_reset_in,
  input wire logic modem_clear,
  input wire logic [1:0] latched_reg_select,
  input wire logic write_high_byte_strobe,
  input wire logic write_low_byte_strobe,
  input wire logic read_strobe,
  input wire logic [15:0] host_addr_data_bus_in,
  output logic [15:0] host_addr_data_bus_out,
  output logic host_addr_data_bus_oe_n,
  output logic tx_done_irq,
  output logic rx_done_irq,
  output logic char_available,
  input wire logic buffer_shift_out,
  output logic buffer_out_ready,
  output logic buffer_in_ready,
  output logic buffer_clear,
  output logic shift_in_low,
  output logic shift_in_high,
  output logic [7:0] rx_char_bus,
  input wire logic line0_rx,
  input wire logic line1_rx,
  input wire logic line2_rx,
  input wire logic line3_rx,
  output logic line0_tx,
  output logic line1_tx,
  output logic line2_tx,
  output logic line3_tx,
  output logic comm_local_loopback,
  output logic comm_terminal_ready,
  output logic comm_rate_select,
  output logic comm_request_send,
  output logic printer_break_detect,
  input wire logic diag_jumper,
  output logic cpu_halt_req
);
  if (SILO_WORDS < SILO_ALARM || STAGE_WORDS < 2) begin : g_bad
    $error("silo or stage depth too small");
  end

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  localparam int PW = 4 + 4 + $bits(host_in_s);
  logic [PW-1:0] s1_q;
  logic [PW-1:0] s2_q;
  logic [PW-1:0] s3_q;
  wire [PW-1:0] pins = {line3_rx, line2_rx, line1_rx, line0_rx,
    system_reset_in, modem_clear, diag_jumper, buffer_shift_out,
    write_high_byte_strobe, write_low_byte_strobe, read_strobe,
    latched_reg_select, host_addr_data_bus_in};
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  host_in_s hs;
  host_in_s hp;
  wire [3:0] rx_s = s2_q[PW-1:PW-4];
  wire sysrst_s = s2_q[PW-5];
  wire mclr_s = s2_q[PW-6];
  wire jumper_s = s2_q[PW-7];
  wire shout_s = s2_q[PW-8];
  wire shout_p = s3_q[PW-8];
  assign hs = s2_q[$bits(host_in_s)-1:0];
  assign hp = s3_q[$bits(host_in_s)-1:0];
  // glue combines the strobes; we act on their rising edges
  wire wr_hi = hs.wr_hi && !hp.wr_hi;
  wire wr_lo = hs.wr_lo && !hp.wr_lo;
  wire rd_rise = hs.rd && !hp.rd;
  wire sel_csr = hs.sel == REG_CSR;
  wire sel_lpr = hs.sel == REG_RBUF_LPR;
  wire sel_tcr = hs.sel == REG_TCR;
  wire sel_tdr = hs.sel == REG_MSR_TDR;

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  logic tie_q, sae_q, rie_q, mse_q, clr_q;
  logic [3:0] txen_q;
  logic [3:0] rxen_q;
  logic [3:0] rate_q [NUM_LINES];
  modem_s modem_q;
  wire clr = clr_q || sysrst_s;
  wire clr_req = wr_lo && sel_csr && hs.data[CSR_CLR];
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clr_q <= 1'b0;
    end else begin
      clr_q <= clr_req;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {tie_q, sae_q, rie_q, mse_q} <= '0;
      txen_q <= '0;
      rxen_q <= '0;
      rate_q <= '{default: RATE_RESET};
    end else if (clr) begin
      {tie_q, sae_q, rie_q, mse_q} <= '0;
      txen_q <= '0;
      rxen_q <= '0;
      rate_q <= '{default: RATE_RESET};
    end else begin
      if (wr_lo && sel_csr) begin
        rie_q <= hs.data[CSR_RIE];
        mse_q <= hs.data[CSR_MSE];
      end
      if (wr_hi && sel_csr) begin
        tie_q <= hs.data[CSR_TIE];
        sae_q <= hs.data[CSR_SAE];
      end
      if (wr_lo && sel_tcr) txen_q <= hs.data[TCR_TXEN +: 4];
      if (wr_hi && sel_lpr) begin
        rate_q[hs.data[LPR_LINE +: 2]] <= hs.data[LPR_RATE +: 4];
        rxen_q[hs.data[LPR_LINE +: 2]] <= hs.data[LPR_RXEN];
      end
    end
  end
  // modem bits exist for the communications line alone
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      modem_q <= '0;
    end else if (clr || mclr_s) begin
      modem_q <= '0;
    end else if (wr_hi && sel_tcr) begin
      modem_q <= hs.data[TCR_MODEM +: 4];
    end
  end
  assign comm_local_loopback = modem_q.llbk;
  assign comm_terminal_ready = modem_q.dtr;
  assign comm_rate_select = modem_q.dsrs;
  assign comm_request_send = modem_q.rts;

  ////////////////////////////////////////////////////////////////////////////
  // per-line receivers and transmitters
  logic [3:0] rx_pend;
  logic [3:0] rx_done;
  logic [3:0] tx_idle;
  logic [3:0] tx_pin;
  rx_char_s rx_hold [NUM_LINES];
  rx_char_s rx_got [NUM_LINES];
  logic [3:0] grant;
  logic [1:0] tline;
  wire tdr_we = wr_lo && sel_tdr && mse_q;
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
    logic [15:0] dv_q;
    logic rbusy_q, tbusy_q, pend_q;
    logic [3:0] rs_q, rb_q, ts_q, tb_q;
    logic [8:0] rsh_q;
    logic [9:0] tsh_q;
    rx_char_s hold_q;
    wire tick = dv_q == 16'h0000;
    wire bit_end = tick && rbusy_q && rs_q == 4'h0;
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) dv_q <= '0;
      else if (tick) dv_q <= div_for(rate_q[i]) - 16'h0001;
      else dv_q <= dv_q - 16'h0001;
    end
    assign rx_done[i] = bit_end && rb_q == 4'h9;
    assign rx_got[i] = '{line: 2'(i), ferr: !rx_s[i], ch: rsh_q[8:1]};
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        rbusy_q <= 1'b0;
        rs_q <= '0;
        rb_q <= '0;
        rsh_q <= '0;
      end else if (clr) begin
        rbusy_q <= 1'b0;
      end else if (tick && !rbusy_q) begin
        if (!rx_s[i] && rxen_q[i] && mse_q) begin
          rbusy_q <= 1'b1;
          rs_q <= 4'h7;
          rb_q <= '0;
        end
      end else if (tick && rs_q != 4'h0) begin
        rs_q <= rs_q - 4'h1;
      end else if (bit_end) begin
        rs_q <= 4'hF;
        rsh_q <= {rx_s[i], rsh_q[8:1]};
        rb_q <= rb_q + 4'h1;
        if (rb_q == 4'h9) rbusy_q <= 1'b0;
      end
    end
    // a new character wins over the grant of the old one
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        pend_q <= 1'b0;
        hold_q <= '0;
      end else if (clr) begin
        pend_q <= 1'b0;
      end else if (rx_done[i]) begin
        pend_q <= 1'b1;
        hold_q <= rx_got[i];
      end else if (grant[i]) begin
        pend_q <= 1'b0;
      end
    end
    assign rx_pend[i] = pend_q;
    assign rx_hold[i] = hold_q;
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        tbusy_q <= 1'b0;
        ts_q <= '0;
        tb_q <= '0;
        tsh_q <= '1;
      end else if (clr) begin
        tbusy_q <= 1'b0;
        tsh_q <= '1;
      end else if (tdr_we && tline == 2'(i) && !tbusy_q) begin
        tbusy_q <= 1'b1;
        ts_q <= 4'hF;
        tb_q <= '0;
        tsh_q <= {1'b1, hs.data[7:0], 1'b0};
      end else if (tick && tbusy_q) begin
        if (ts_q != 4'h0) begin
          ts_q <= ts_q - 4'h1;
        end else begin
          ts_q <= 4'hF;
          tsh_q <= {1'b1, tsh_q[9:1]};
          tb_q <= tb_q + 4'h1;
          if (tb_q == 4'h9) tbusy_q <= 1'b0;
        end
      end
    end
    assign tx_idle[i] = !tbusy_q;
    assign tx_pin[i] = tsh_q[0];
  end
  assign {line3_tx, line2_tx, line1_tx, line0_tx} = tx_pin;

  ////////////////////////////////////////////////////////////////////////////
  // transmit scanner
  wire [3:0] tx_ready = txen_q & tx_idle & {4{mse_q}};
  wire trdy = |tx_ready;
  assign tline = first_set(tx_ready);
  assign tx_done_irq = trdy && tie_q;

  ////////////////////////////////////////////////////////////////////////////
  // staging fifo and silo loader
  rx_char_s st_in, st_out;
  logic st_ready, st_valid;
  load_e ld_q;
  wire [1:0] pick = first_set(rx_pend);
  wire st_push = |rx_pend && st_ready;
  assign grant = st_push ? 4'(1 << pick) : 4'h0;
  assign st_in = rx_hold[pick];
  serial_fifo #(.WIDTH($bits(rx_char_s)), .DEPTH(STAGE_WORDS)) u_stage (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(clr),
    .in_valid(|rx_pend),
    .in_ready(st_ready),
    .in_data(st_in),
    .out_valid(st_valid),
    .out_ready(shift_in_high),
    .out_data(st_out),
    .count()
  );
  assign shift_in_low = ld_q == LD_LOW
    && buffer_in_ready;
  assign shift_in_high = ld_q == LD_HIGH
    && buffer_in_ready;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ld_q <= LD_IDLE;
      rx_char_bus <= '0;
    end else if (clr) begin
      ld_q <= LD_IDLE;
    end else begin
      case (ld_q)
        LD_IDLE: if (st_valid) begin
          rx_char_bus <= st_out.ch;
          ld_q <= LD_LOW;
        end
        LD_LOW: if (shift_in_low) begin
          rx_char_bus <= {1'b1, 1'b0, st_out.ferr, 3'b000, st_out.line};
          ld_q <= LD_HIGH;
        end
        LD_HIGH: if (shift_in_high) ld_q <= LD_IDLE;
        default: ld_q <= LD_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared receive silo
  logic [7:0] lo_q;
  logic [15:0] silo_out;
  logic [$clog2(SILO_WORDS):0] silo_cnt;
  wire pop_sh = shout_s && !shout_p;
  assign buffer_clear = clr;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) lo_q <= '0;
    else if (shift_in_low) lo_q <= rx_char_bus;
  end
  serial_fifo #(.WIDTH(16), .DEPTH(SILO_WORDS)) u_silo (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(buffer_clear),
    .in_valid(shift_in_high),
    .in_ready(buffer_in_ready),
    .in_data({rx_char_bus, lo_q}),
    .out_valid(buffer_out_ready),
    .out_ready(pop_sh),
    .out_data(silo_out),
    .count(silo_cnt)
  );
  wire silo_alarm = sae_q && silo_cnt >= SILO_ALARM;
  assign char_available = buffer_out_ready && mse_q;
  assign rx_done_irq = rie_q && (char_available || !buffer_in_ready
    || silo_alarm);

  ////////////////////////////////////////////////////////////////////////////
  // printer break and halt
  wire brk_in = rx_done[PRINTER_LINE] && rx_got[PRINTER_LINE].ferr
    && rx_got[PRINTER_LINE].ch == 8'h00;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) printer_break_detect <= 1'b0;
    else if (brk_in) printer_break_detect <= 1'b1;
    else if (rx_done[PRINTER_LINE] || clr) printer_break_detect <= 1'b0;
  end
  assign cpu_halt_req = printer_break_detect && jumper_s;

  ////////////////////////////////////////////////////////////////////////////
  // host read path
  wire [15:0] csr_rd = {trdy, tie_q, silo_alarm, sae_q, 2'b00, tline,
    char_available, rie_q, mse_q, 5'b00000};
  wire [15:0] rd_mux = sel_csr ? csr_rd :
    sel_lpr ? (buffer_out_ready ? silo_out : READ_NONE) :
    sel_tcr ? {4'h0, modem_q, 4'h0, txen_q} : READ_NONE;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) host_addr_data_bus_out <= '0;
    else if (rd_rise) host_addr_data_bus_out <= rd_mux;
  end
  assign host_addr_data_bus_oe_n = !(hs.rd && hp.rd);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic low_seen_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) low_seen_q <= 1'b0;
    else if (shift_in_low) low_seen_q <= 1'b1;
    else if (shift_in_high || clr) low_seen_q <= 1'b0;
  end
  property p_low_first;
    @(posedge clk_sys) disable iff (rst) shift_in_high |-> low_seen_q;
  endproperty
  a_low_first: assert property (p_low_first)
    else $error("high byte shifted before low byte");
  property p_no_shift_full;
    @(posedge clk_sys) disable iff (rst)
      (silo_cnt == SILO_WORDS) |-> !shift_in_low && !shift_in_high;
  endproperty
  a_no_shift_full: assert property (p_no_shift_full)
    else $error("shift into full silo");
  property p_clear_empties;
    @(posedge clk_sys) disable iff (rst)
      buffer_clear |=> silo_cnt == 0 && !buffer_out_ready;
  endproperty
  a_clear_empties: assert property (p_clear_empties)
    else $error("silo not empty after clear");
  property p_out_ready;
    @(posedge clk_sys) disable iff (rst)
      shift_in_high && !buffer_clear |=> buffer_out_ready;
  endproperty
  a_out_ready: assert property (p_out_ready)
    else $error("out-ready missing after load");
  property p_hold_till_shift;
    @(posedge clk_sys) disable iff (rst)
      !pop_sh && !buffer_clear |=> silo_cnt >= $past(silo_cnt);
  endproperty
  a_hold_till_shift: assert property (p_hold_till_shift)
    else $error("silo released without shift-out");
  property p_rx_irq;
    @(posedge clk_sys) disable iff (rst)
      rie_q && buffer_out_ready && mse_q |-> rx_done_irq;
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("receive interrupt missing");
  property p_tx_irq;
    @(posedge clk_sys) disable iff (rst)
      tie_q && mse_q && (txen_q & tx_idle) != 4'h0 |-> tx_done_irq;
  endproperty
  a_tx_irq: assert property (p_tx_irq)
    else $error("transmit interrupt missing");
  property p_bus_drive;
    @(posedge clk_sys) disable iff (rst)
      !host_addr_data_bus_oe_n |-> $past(read_strobe, 2)
        && $past(read_strobe, 3);
  endproperty
  a_bus_drive: assert property (p_bus_drive)
    else $error("bus driven outside read strobe");
  property p_break;
    @(posedge clk_sys) disable iff (rst)
      brk_in ##1 jumper_s |-> printer_break_detect && cpu_halt_req;
  endproperty
  a_break: assert property (p_break)
    else $error("printer break not flagged");
  property p_modem_clear;
    @(posedge clk_sys) disable iff (rst)
      mclr_s |=> !comm_terminal_ready && !comm_request_send;
  endproperty
  a_modem_clear: assert property (p_modem_clear)
    else $error("modem outputs not cleared");
  c_load: cover property (@(posedge clk_sys) shift_in_low ##1 shift_in_high);
  c_tx: cover property (@(posedge clk_sys) tdr_we);
  c_halt: cover property (@(posedge clk_sys) cpu_halt_req);
endmodule : quad_serial_line_silo_controller
`default_nettype wire

//--- testbench/host_glue_model.sv
// host glue model: strobe gating and the shared bus wire
`timescale 1ns/1ps
`default_nettype none
module host_glue_model (
  input wire logic lower_column_strobe,
  input wire logic upper_column_strobe,
  input wire logic bus_write_ind,
  input wire logic bus_direction,
  input wire logic bus_data_strobe,
  input wire logic controller_select,
  input wire logic [15:0] host_drive,
  input wire logic [15:0] dev_drive,
  input wire logic dev_oe_n,
  output logic write_high_byte_strobe,
  output logic write_low_byte_strobe,
  output logic read_strobe,
  output logic [15:0] bus_wire
);
  assign write_high_byte_strobe = upper_column_strobe & bus_write_ind
    & controller_select;
  assign write_low_byte_strobe = lower_column_strobe & bus_write_ind
    & controller_select;
  assign read_strobe = bus_direction & bus_data_strobe
    & controller_select;
  // host stays off the wire while the device drives it
  assign bus_wire = dev_oe_n ? host_drive : dev_drive;
endmodule : host_glue_model
`default_nettype wire

//--- testbench/quad_serial_line_silo_controller_tb_top.sv
// self-checking bench for the quad serial line controller
`timescale 1ns/1ps
`default_nettype none
module quad_serial_line_silo_controller_tb_top
  import serial_ctrl_pkg::*;
;
  localparam int BIT = 16 * (CLK_HZ / (OVERSAMPLE * 19200));
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic mclr = 1'b0, jmp = 1'b0, shout = 1'b0, clr_seen = 1'b0;
  logic c0 = 1'b0, c1 = 1'b0, wri = 1'b0, dir = 1'b0, ds = 1'b0, cs = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [15:0] hd = 16'h0000;
  logic [15:0] q;
  logic [3:0] rx = 4'hF;
  wire logic whb, wlb, rds, oe_n, txi, rxi, cav, bor, bir, bclr;
  wire logic sil, sih, brk, halt;
  wire logic [15:0] bus_w, bus_out;
  wire logic [7:0] rxc;
  wire logic [3:0] tx, mdm;
  wire logic [9:0] obs;
  int err_count = 0;
  int samples_checked = 0;

  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (bclr) clr_seen <= 1'b1;
  assign obs = {tx[1], txi, halt, brk, bclr, rxi, cav, bor, sih, sil};

  ////////////////////////////////////////////////////////////////////////
  quad_serial_line_silo_controller DUT (
    .clk_sys(clk_sys), .rst(rst), .system_reset_in(1'b0),
    .modem_clear(mclr), .latched_reg_select(sel),
    .write_high_byte_strobe(whb), .write_low_byte_strobe(wlb),
    .read_strobe(rds), .host_addr_data_bus_in(bus_w),
    .host_addr_data_bus_out(bus_out), .host_addr_data_bus_oe_n(oe_n),
    .tx_done_irq(txi), .rx_done_irq(rxi), .char_available(cav),
    .buffer_shift_out(shout), .buffer_out_ready(bor),
    .buffer_in_ready(bir), .buffer_clear(bclr), .shift_in_low(sil),
    .shift_in_high(sih), .rx_char_bus(rxc), .line0_rx(rx[0]),
    .line1_rx(rx[1]), .line2_rx(rx[2]), .line3_rx(rx[3]),
    .line0_tx(tx[0]), .line1_tx(tx[1]), .line2_tx(tx[2]),
    .line3_tx(tx[3]), .comm_local_loopback(mdm[3]),
    .comm_terminal_ready(mdm[2]), .comm_rate_select(mdm[1]),
    .comm_request_send(mdm[0]), .printer_break_detect(brk),
    .diag_jumper(jmp), .cpu_halt_req(halt)
  );
  host_glue_model glue (
    .lower_column_strobe(c0), .upper_column_strobe(c1),
    .bus_write_ind(wri), .bus_direction(dir), .bus_data_strobe(ds),
    .controller_select(cs), .host_drive(hd), .dev_drive(bus_out),
    .dev_oe_n(oe_n), .write_high_byte_strobe(whb),
    .write_low_byte_strobe(wlb), .read_strobe(rds), .bus_wire(bus_w)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] got,
      input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    sel <= a;
    hd <= d;
    {c0, c1, wri, cs} <= 4'hF;
    repeat (4) @(posedge clk_sys);
    {c0, c1, wri, cs} <= 4'h0;
    repeat (4) @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [1:0] a);
    @(posedge clk_sys);
    sel <= a;
    hd <= ~hd;
    {dir, ds, cs} <= 3'h7;
    repeat (4) @(posedge clk_sys);
    #1;
    check("bus driven", 16'(oe_n), 16'h0);
    q = bus_out;
    @(posedge clk_sys);
    {dir, ds, cs} <= 3'h0;
    repeat (4) @(posedge clk_sys);
    #1;
    check("bus released", 16'(oe_n), 16'h1);
  endtask : rd

  task automatic wait_bit(input int i, input logic v, input int lim);
    for (int n = 0; n < lim && obs[i] !== v; n++) begin
      @(posedge clk_sys);
      #1;
    end
  endtask : wait_bit

  // start, eight data bits lsb first, then the stop level is left on
  task automatic send(input int ln, input logic [7:0] ch, input logic sb);
    @(posedge clk_sys);
    rx[ln] <= 1'b0;
    for (int b = 0; b < 9; b++) begin
      repeat (BIT) @(posedge clk_sys);
      rx[ln] <= (b == 8) ? sb : ch[b];
    end
  endtask : send

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    check("reset", {tx, 8'h0, bir, txi, rxi, 1'b0}, 16'hF008);
    wr(REG_TCR, 16'h0F02);
    wr(REG_CSR, 16'h4060);
    rd(REG_CSR);
    check("csr", q & 16'h5070, 16'h4060);
    rd(REG_TCR);
    check("tcr", q, 16'h0F02);
    rd(REG_MSR_TDR);
    check("modem status", q, READ_NONE);
    check("modem out", 16'(mdm), 16'hF);
    wait_bit(8, 1'b1, 200);
    check("tx done irq", 16'(txi), 16'h1);
    wr(REG_MSR_TDR, 16'h0055);
    wait_bit(9, 1'b0, 2 * BIT);
    check("start bit", 16'(tx), 16'hD);
    mclr <= 1'b1;
    repeat (4) @(posedge clk_sys);
    mclr <= 1'b0;
    #1;
    check("modem clear", 16'(mdm), 16'h0);
    $display("test registers done");
  endtask : t_regs

  task automatic t_rx;
    wr(REG_RBUF_LPR, 16'h1F02);
    send(2, 8'hA5, 1'b1);
    wait_bit(0, 1'b1, 3 * BIT);
    check("low strobe", {sil, sih, 6'h0, rxc}, 16'h80A5);
    @(posedge clk_sys);
    #1;
    check("high strobe", {sil, sih, 6'h0, rxc}, 16'h4082);
    wait_bit(2, 1'b1, 8);
    check("out ready", 16'(bor), 16'h1);
    check("rx irq", 16'(rxi), 16'h1);
    repeat (20) @(posedge clk_sys);
    #1;
    check("char held", 16'(cav), 16'h1);
    rd(REG_RBUF_LPR);
    check("silo word", q, 16'h82A5);
    @(posedge clk_sys);
    shout <= 1'b1;
    repeat (4) @(posedge clk_sys);
    shout <= 1'b0;
    wait_bit(2, 1'b0, 8);
    check("popped", {bor, cav}, 16'h0);
    $display("test receive done");
  endtask : t_rx

  task automatic t_break;
    wr(REG_RBUF_LPR, 16'h1F03);
    jmp <= 1'b1;
    send(3, 8'h00, 1'b0);
    wait_bit(7, 1'b1, 3 * BIT);
    check("break halt", {brk, halt}, 16'h3);
    @(posedge clk_sys);
    rx[3] <= 1'b1;
    jmp <= 1'b0;
    wait_bit(2, 1'b1, 3 * BIT);
    check("halt off", {brk, halt, bor}, 16'h5);
    wr(REG_CSR, 16'h0010);
    check("clear", {clr_seen, bor, bir}, 16'h5);
    $display("test break and clear done");
  endtask : t_break

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    t_regs;
    t_rx;
    t_break;
    print_verdict;
  end

  initial begin
    repeat (90000) @(posedge clk_sys);
    err_count++;
    print_verdict;
  end
endmodule : quad_serial_line_silo_controller_tb_top
`default_nettype wire
